/* core/scm_map.svh */
// Address map, field positions and reset values of the connection store.
// Assumes byte addressing on a 19-bit host address bus.
`ifndef SCM_MAP_SVH
`define SCM_MAP_SVH

// ==========================================================================
// Host address decode
`define SCM_ADDR_W   19
`define SCM_CM_TOP   19'h1_FFFF
`define SCM_DM_LO    19'h2_8000
`define SCM_DM_HI    19'h2_FFFF
`define SCM_GRP_MSB  16
`define SCM_GRP_LSB  12
`define SCM_OFS_MSB  11
`define SCM_WRD_LSB  2

// ==========================================================================
// Stream end offsets inside a group block, per group rate
`define SCM_A_END_65 12'hFFF
`define SCM_A_END_32 12'h7FF
`define SCM_B_END_32 12'hFFF
`define SCM_A_END_16 12'h3FF
`define SCM_B_END_16 12'h7FF
`define SCM_A_END_8  12'h1FF
`define SCM_B_END_8  12'h3FF

// ==========================================================================
// Storage shape and reset values
`define SCM_IDX_W    15
`define SCM_IDX_LAST 15'h7FFF
`define SCM_IDX_ONE  15'h0001
`define SCM_WORD_RST 32'h0000_0000

`endif

/* core/scm_pkg.sv */
// Types shared by the connection store decoder, its host model and its bench.
// Assumes scm_map.svh is on the include path.
package scm_pkg;

  // ========================================================================
  // Group rate codes
  typedef enum logic [1:0] {
    SCM_RATE_8,
    SCM_RATE_16,
    SCM_RATE_32,
    SCM_RATE_65
  } scm_rate_e;

  typedef scm_rate_e [31:0] scm_grp_rate_t;

  // ========================================================================
  // Host request and answer
  typedef struct packed {
    logic        we;
    logic [18:0] addr;
    logic [31:0] wdata;
  } scm_req_s;

  typedef struct packed {
    logic        bus_error_indication;
    logic        hit;
    logic        strm_b;
    logic [31:0] rdata;
  } scm_rsp_s;

endpackage

/* core/scm_mem.sv */
// Single-port word store of the connection settings, registered read.
// Assumes one access per cycle; a cycle without a read returns zero.
module scm_mem (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        we,
  input  wire logic        re,
  input  wire logic [14:0] idx,
  input  wire logic [31:0] wdata,
  output logic      [31:0] rdata_q
);
  `include "scm_map.svh"

  logic [31:0] mem [0:32767];
  logic [31:0] rdata_d;

  // Array has no reset; the caller sweeps it with zeros after reset.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[idx] <= wdata;
    end
  end

  // Zero when no read, so an error answer never leaks stale data.
  always_comb begin
    rdata_d = `SCM_WORD_RST;
    if (re) begin
      rdata_d = mem[idx];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= `SCM_WORD_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule

/* core/scm_decode.sv */
// Host-side decoder and storage of the per-timeslot connection words.
// Assumes group rates come in as stable levels from the group settings.
module scm_decode (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire scm_pkg::scm_grp_rate_t grp_rate,
  input  wire logic                   req_valid,
  input  wire scm_pkg::scm_req_s      req,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output scm_pkg::scm_rsp_s           rsp,
  output logic                        init_busy
);
  import scm_pkg::*;
  `include "scm_map.svh"

  // ========================================================================
  // Address classification
  typedef enum logic [1:0] {
    SCM_CLS_HIT,
    SCM_CLS_ERR,
    SCM_CLS_OTHER
  } scm_cls_e;

  typedef enum logic {
    SCM_ST_INIT,
    SCM_ST_RUN
  } scm_st_e;

  // Offset limits of both streams for one rate.
  function automatic logic [23:0] stream_ends(input scm_rate_e r);
    unique case (r)
      SCM_RATE_65: stream_ends = {`SCM_A_END_65, `SCM_A_END_65};
      SCM_RATE_32: stream_ends = {`SCM_A_END_32, `SCM_B_END_32};
      SCM_RATE_16: stream_ends = {`SCM_A_END_16, `SCM_B_END_16};
      SCM_RATE_8:  stream_ends = {`SCM_A_END_8,  `SCM_B_END_8};
    endcase
  endfunction

  // Class of one host access under the current group rates.
  function automatic scm_cls_e classify(input logic          we,
                                        input logic [18:0]   a,
                                        input scm_grp_rate_t gr);
    logic [23:0] ends;
    logic [11:0] ofs;
    ends = stream_ends(gr[a[`SCM_GRP_MSB:`SCM_GRP_LSB]]);
    ofs  = a[`SCM_OFS_MSB:0];
    if (a <= `SCM_CM_TOP) begin
      classify = (ofs <= ends[11:0]) ? SCM_CLS_HIT : SCM_CLS_ERR;
    end else if (a >= `SCM_DM_LO && a <= `SCM_DM_HI) begin
      classify = we ? SCM_CLS_ERR : SCM_CLS_OTHER;
    end else if (a > `SCM_DM_HI) begin
      classify = SCM_CLS_ERR;
    end else begin
      classify = SCM_CLS_OTHER;
    end
  endfunction

  // Word index: group in the top bits, timeslot word below.
  // group plus offset
  function automatic logic [14:0] word_idx(input logic [18:0] a);
    word_idx = {a[`SCM_GRP_MSB:`SCM_GRP_LSB], a[`SCM_OFS_MSB:`SCM_WRD_LSB]};
  endfunction

  // ========================================================================
  // Sweep and answer state
  scm_st_e     st_q, st_d;
  logic [14:0] cnt_q, cnt_d;
  logic        vld_q, vld_d;
  logic        bus_error_indication_q, bus_error_indication_d;
  logic        hit_q, hit_d;
  logic        strb_q, strb_d;
  logic        taken;
  scm_cls_e    cls;
  logic        mem_we, mem_re;
  logic [14:0] mem_idx;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic [23:0] cur_ends;

  assign req_ready = (st_q == SCM_ST_RUN);
  assign taken     = req_valid && req_ready;
  assign cls       = classify(req.we, req.addr, grp_rate);
  assign cur_ends  =
    stream_ends(grp_rate[req.addr[`SCM_GRP_MSB:`SCM_GRP_LSB]]);
  assign init_busy = (st_q == SCM_ST_INIT);

  // Next state: sweep every word once, then serve the host.
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    vld_d  = taken;
    bus_error_indication_d = taken && (cls == SCM_CLS_ERR);
    hit_d  = taken && (cls == SCM_CLS_HIT);
    strb_d = taken && (cls == SCM_CLS_HIT)
             && (req.addr[`SCM_OFS_MSB:0] > cur_ends[23:12]);
    unique case (st_q)
      SCM_ST_INIT: begin
        cnt_d = cnt_q + `SCM_IDX_ONE;
        if (cnt_q == `SCM_IDX_LAST) begin
          st_d = SCM_ST_RUN;
        end
      end
      SCM_ST_RUN: begin
        st_d = SCM_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= SCM_ST_INIT;
      cnt_q  <= '0;
      vld_q  <= 1'b0;
      bus_error_indication_q <= 1'b0;
      hit_q  <= 1'b0;
      strb_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      vld_q  <= vld_d;
      bus_error_indication_q <= bus_error_indication_d;
      hit_q  <= hit_d;
      strb_q <= strb_d;
    end
  end

  // ========================================================================
  // Storage port: sweep owns it during init, the host afterwards.
  // group block
  always_comb begin
    mem_we    = 1'b0;
    mem_re    = 1'b0;
    mem_idx   = word_idx(req.addr);
    mem_wdata = req.wdata;
    if (st_q == SCM_ST_INIT) begin
      mem_we    = 1'b1;
      mem_idx   = cnt_q;
      mem_wdata = `SCM_WORD_RST;
    end else if (taken && cls == SCM_CLS_HIT) begin
      mem_we = req.we;
      mem_re = !req.we;
    end
  end

  scm_mem u_mem (
    .clk     (clk),
    .rst_b   (rst_b),
    .we      (mem_we),
    .re      (mem_re),
    .idx     (mem_idx),
    .wdata   (mem_wdata),
    .rdata_q (mem_rdata)
  );

  assign rsp_valid  = vld_q;
  assign rsp.bus_error_indication   = bus_error_indication_q;
  assign rsp.hit    = hit_q;
  assign rsp.strm_b = strb_q;
  assign rsp.rdata  = mem_rdata;

  // ========================================================================
  // Checks
  logic        lw_vld_q;
  logic [14:0] lw_idx_q;
  logic [31:0] lw_dat_q;
  logic [16:0] sweep_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lw_vld_q <= 1'b0;
      lw_idx_q <= '0;
      lw_dat_q <= '0;
      sweep_q  <= '0;
    end else begin
      if (taken && req.we && cls == SCM_CLS_HIT) begin
        lw_vld_q <= 1'b1;
        lw_idx_q <= word_idx(req.addr);
        lw_dat_q <= req.wdata;
      end
      if (st_q == SCM_ST_INIT) begin
        sweep_q <= sweep_q + 17'h0_0001;
      end
    end
  end

  property p_sweep_zero;
    @(posedge clk) disable iff (!rst_b)
    init_busy |-> mem_we && mem_wdata == 32'h0000_0000 && !req_ready;
  endproperty
  a_sweep_zero: assert property (p_sweep_zero) else $error("bad sweep");

  property p_sweep_len;
    @(posedge clk) disable iff (!rst_b)
    $fell(init_busy) |-> sweep_q == 17'h0_8000;
  endproperty
  a_sweep_len: assert property (p_sweep_len) else $error("sweep length");

  property p_cm_hit;
    @(posedge clk) disable iff (!rst_b)
    taken && req.addr <= 19'h1_FFFF && req.addr[11:0] <= 12'h3FF
    |=> rsp_valid && rsp.hit && !rsp.bus_error_indication;
  endproperty
  a_cm_hit: assert property (p_cm_hit) else $error("cm miss");

  property p_rate65;
    @(posedge clk) disable iff (!rst_b)
    taken && req.addr <= 19'h1_FFFF && grp_rate[req.addr[16:12]] == SCM_RATE_65
    |=> rsp.hit && !rsp.strm_b;
  endproperty
  a_rate65: assert property (p_rate65) else $error("65 split");

  property p_rate8_b;
    @(posedge clk) disable iff (!rst_b)
    taken && req.addr <= 19'h1_FFFF && grp_rate[req.addr[16:12]] == SCM_RATE_8
    && req.addr[11:0] >= 12'h200 && req.addr[11:0] <= 12'h3FF
    |=> rsp.hit && rsp.strm_b;
  endproperty
  a_rate8_b: assert property (p_rate8_b) else $error("8 split");

  property p_gap_err;
    @(posedge clk) disable iff (!rst_b)
    taken && req.addr <= 19'h1_FFFF && req.addr[11:0] >= 12'h800
    && grp_rate[req.addr[16:12]] == SCM_RATE_16
    |=> rsp.bus_error_indication && !rsp.hit && rsp.rdata == 32'h0000_0000;
  endproperty
  a_gap_err: assert property (p_gap_err) else $error("gap no error");

  property p_dm_wr;
    @(posedge clk) disable iff (!rst_b)
    taken && req.we && req.addr >= 19'h2_8000 && req.addr <= 19'h2_FFFF
    |=> rsp_valid && rsp.bus_error_indication && !rsp.hit && rsp.rdata == 32'h0000_0000;
  endproperty
  a_dm_wr: assert property (p_dm_wr) else $error("dm write");

  property p_readback;
    @(posedge clk) disable iff (!rst_b)
    taken && !req.we && cls == SCM_CLS_HIT && lw_vld_q
    && word_idx(req.addr) == lw_idx_q
    |=> rsp.rdata == lw_dat_q;
  endproperty
  a_readback: assert property (p_readback) else $error("readback");

  property p_one_rsp;
    @(posedge clk) disable iff (!rst_b)
    !taken |=> !rsp_valid;
  endproperty
  a_one_rsp: assert property (p_one_rsp) else $error("stray answer");

  // Second stream of group 12 at 32 Mbps must land at C800 to CFFF.
  property p_grp_ofs;
    @(posedge clk) disable iff (!rst_b)
    taken && req.addr[18:12] == 7'h0C && grp_rate[12] == SCM_RATE_32
    && req.addr[11:0] >= 12'h800
    |=> rsp_valid && rsp.hit && rsp.strm_b && !rsp.bus_error_indication;
  endproperty
  a_grp_ofs: assert property (p_grp_ofs) else $error("group offset");

endmodule

/* tb/scm_host_model.sv */
// Behavioural host issuing one connection-store access per go pulse.
// Assumes one clock domain and the decoder's valid/ready handshake.
module scm_host_model (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              go,
  input  wire scm_pkg::scm_req_s cmd,
  input  wire logic              req_ready,
  output logic                   req_valid,
  output scm_pkg::scm_req_s      req
);
  timeunit 1ns;
  timeprecision 1ps;
  import scm_pkg::*;

  // ==========================================================================
  // Request hold and release
  // host forms address
  // The request is held until taken; afterwards the bus shows the inverse
  // of the last request, so stale values never pass for a fresh one.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_valid <= 1'b0;
      req       <= '0;
    end else if (req_valid && req_ready) begin
      req_valid <= 1'b0;
      req       <= scm_req_s'(~req);
    end else if (!req_valid && go) begin
      req_valid <= 1'b1;
      req       <= cmd;
    end
  end
endmodule

/* tb/scm_decode_tb_top.sv */
// Self-checking bench of the connection-store decoder.
// Assumes the host model file and the core files are compiled first.
module scm_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scm_pkg::*;

  typedef struct packed {
    logic        we;
    logic [18:0] a;
    logic [31:0] d;
    scm_rsp_s    e;
  } scm_row_s;

  localparam logic [31:0] Z = 32'h0000_0000;

  logic          clk = 1'b0;
  logic          rst_b = 1'b0;
  logic          go = 1'b0;
  scm_req_s      cmd = '0;
  scm_grp_rate_t grp_rate;
  logic          req_valid;
  logic          req_ready;
  logic          rsp_valid;
  logic          init_busy;
  scm_req_s      req;
  scm_rsp_s      rsp;
  int            error_cnt = 0;
  int            num_checks = 0;
  int            n;

  // Rows: access, then expected bus_error_indication, hit, second stream and read data.
  scm_row_s rows [20] = '{
    '{1'b1, 19'h0_C800, 32'h1111_2222, {3'b011, Z}},
    '{1'b0, 19'h0_C800, Z, {3'b011, 32'h1111_2222}},
    '{1'b0, 19'h0_C804, Z, {3'b011, Z}},
    '{1'b1, 19'h0_0FFC, 32'hA5A5_0001, {3'b010, Z}},
    '{1'b0, 19'h0_0FFD, Z, {3'b010, 32'hA5A5_0001}},
    '{1'b0, 19'h0_17FC, Z, {3'b010, Z}},
    '{1'b0, 19'h0_1800, Z, {3'b011, Z}},
    '{1'b0, 19'h0_2400, Z, {3'b011, Z}},
    '{1'b1, 19'h0_2800, 32'h5555_5555, {3'b100, Z}},
    '{1'b0, 19'h0_2800, Z, {3'b100, Z}},
    '{1'b0, 19'h0_31FC, Z, {3'b010, Z}},
    '{1'b0, 19'h0_3200, Z, {3'b011, Z}},
    '{1'b0, 19'h0_3400, Z, {3'b100, Z}},
    '{1'b1, 19'h2_8000, 32'h5555_5555, {3'b100, Z}},
    '{1'b0, 19'h0_8000, Z, {3'b010, Z}},
    '{1'b0, 19'h2_8000, Z, {3'b000, Z}},
    '{1'b0, 19'h2_0000, Z, {3'b000, Z}},
    '{1'b0, 19'h3_8000, Z, {3'b100, Z}},
    '{1'b1, 19'h1_FFFC, 32'h0000_BEEF, {3'b010, Z}},
    '{1'b0, 19'h1_FFFC, Z, {3'b010, 32'h0000_BEEF}}
  };

  always #5 clk = ~clk;

  scm_decode uut (
    .clk       (clk),
    .rst_b     (rst_b),
    .grp_rate  (grp_rate),
    .req_valid (req_valid),
    .req       (req),
    .req_ready (req_ready),
    .rsp_valid (rsp_valid),
    .rsp       (rsp),
    .init_busy (init_busy)
  );

  scm_host_model host (
    .clk       (clk),
    .rst_b     (rst_b),
    .go        (go),
    .cmd       (cmd),
    .req_ready (req_ready),
    .req_valid (req_valid),
    .req       (req)
  );

  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Reset checks, then a bounded wait for the zero sweep to end.
  task automatic reset_and_sweep();
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk({req_ready, rsp_valid, init_busy}, 3'b001);
    rst_b = 1'b1;
    n = 0;
    while (!req_ready && n < 40000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n, 32768); // sweep length
    // A sweep that never ends has already counted a mismatch above.
    if (!req_ready) begin
      give_verdict();
    end
  endtask

  // One access through the host model; the answer stands one cycle only.
  task automatic acc(input scm_row_s r);
    cmd = {r.we, r.a, r.d};
    go = 1'b1;
    @(posedge clk);
    #1;
    go = 1'b0;
    n = 0;
    while (!rsp_valid && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (!rsp_valid) begin
      error_cnt++;
      give_verdict();
    end else begin
      chk(rsp, r.e);
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    for (int g = 0; g < 32; g++) begin
      grp_rate[g] = SCM_RATE_65;
    end
    grp_rate[1] = SCM_RATE_32;
    grp_rate[2] = SCM_RATE_16;
    grp_rate[3] = SCM_RATE_8;
    grp_rate[12] = SCM_RATE_32;
    reset_and_sweep();
    foreach (rows[i]) begin
      acc(rows[i]);
    end
    grp_rate[12] = SCM_RATE_8;
    acc(scm_row_s'{1'b0, 19'h0_C800, Z, {3'b100, Z}});
    acc(scm_row_s'{1'b0, 19'h0_C200, Z, {3'b011, Z}});
    reset_and_sweep();
    acc(scm_row_s'{1'b0, 19'h0_0FFC, Z, {3'b010, Z}});
    give_verdict();
  end
endmodule
